/* File: design/rx_flags_pkg.sv */
// Shared constants and carrier types of the receive FIFO status flag block.
package rx_flags_pkg;

	// Default FIFO depth in characters and character width in bits.
	localparam int DEF_DEPTH = 256;
	localparam int DEF_WIDTH = 10;

	// Consecutive read-clock edges with the clear input low that start a FIFO clear.
	localparam logic [2:0] CLEAR_EDGES = 3'h7;

	// Clear sequencer states.
	typedef enum logic [1:0] {
		CLR_IDLE = 2'b00,
		CLR_COUNT = 2'b01,
		CLR_ACTIVE = 2'b10
	} clear_state_t;

	// Pin inputs that arrive from outside the mclk domain.
	typedef struct packed {
		logic rclk;
		logic cs_n;
		logic bypass_n;
		logic clear_n;
		logic oe_n;
		logic pol;
		logic coding_bypass;
		logic chip_reset_n;
	} pins_t;

	// Pins read as idle after reset: chip select and clear released, chip reset held.
	localparam pins_t PINS_RESET = pins_t'(8'h78);

	// Flag pin values after reset: not driven; half deasserted, empty asserted under the reset polarity.
	localparam logic FLAG_RESET = 1'h0;
	localparam logic OE_RESET = 1'h0;

endpackage : rx_flags_pkg

/* File: design/rx_fifo_flags.sv */
// Receive FIFO with half-full and empty status flag pins updated on the host read clock.
`timescale 1ns/10ps
`default_nettype none

module rx_fifo_flags
	import rx_flags_pkg::*;
#(
	parameter int DEPTH = DEF_DEPTH,
	parameter int WIDTH = DEF_WIDTH
) (
	// Clock, reset and clock enable.
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// Host pins, asynchronous to mclk.
	input wire logic rx_read_clock,
	input wire logic chip_select_n,
	input wire logic fifo_bypass_n,
	input wire logic rx_fifo_clear_n,
	input wire logic rx_output_enable_n,
	input wire logic flag_polarity_select,
	input wire logic coding_bypass,
	input wire logic chip_reset_n,
	// Decoded characters from the receiver, mclk domain.
	input wire logic char_write,
	input wire logic [WIDTH-1:0] char_data,
	input wire logic bypass_valid,
	input wire logic bypass_sync,
	input wire logic [WIDTH-1:0] bypass_data,
	// Status flag pins with their output enables.
	output logic rx_half_flag,
	output logic rx_half_flag_oe,
	output logic rx_empty_flag,
	output logic rx_empty_flag_oe,
	// Parallel data and read indication.
	output logic [WIDTH-1:0] rx_parallel_out,
	output logic rx_read_taken,
	output logic clear_active
);

	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = PTR_W + 1;
	localparam logic [CNT_W-1:0] HALF_LEVEL = CNT_W'(DEPTH / 2);
	localparam logic [CNT_W-1:0] FULL_LEVEL = CNT_W'(DEPTH);

	initial begin
		if (DEPTH < 8 || (DEPTH & (DEPTH - 1)) != 0) begin
			$error("DEPTH must be a power of two of at least 8");
		end
		if (WIDTH < 1) begin
			$error("WIDTH must be at least 1");
		end
	end

	typedef struct packed {
		pins_t s1;
		pins_t s2;
		logic rclk_prev;
		clear_state_t fsm;
		logic [2:0] clr_cnt;
		logic [PTR_W-1:0] wptr;
		logic [PTR_W-1:0] rptr;
		logic [CNT_W-1:0] count;
		logic half;
		logic half_oe;
		logic empty;
		logic empty_oe;
		logic [WIDTH-1:0] data;
		logic taken;
		logic clearing;
	} state_t;

	state_t st;
	state_t next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic upd;
	logic fifo_mode;
	logic arm;
	logic read_try;
	logic read_ok;
	logic wr_ok;
	logic empty_now;

	// Level of the flag pin for a logical empty state under the selected polarity.
	function automatic logic flag_level(input logic asserted, input logic pol);
		flag_level = pol ? asserted : ~asserted;
	endfunction : flag_level

	//////////////////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		next_st = st;
		// Every pin passes two flops; only the second stage is ever inspected.
		next_st.s1 = '{rx_read_clock, chip_select_n, fifo_bypass_n, rx_fifo_clear_n,
			rx_output_enable_n, flag_polarity_select, coding_bypass, chip_reset_n};
		next_st.s2 = st.s1;
		next_st.rclk_prev = st.s2.rclk;
		next_st.taken = 1'b0;
		upd = st.s2.rclk && !st.rclk_prev;
		fifo_mode = st.s2.bypass_n;
		arm = fifo_mode && st.s2.oe_n && !st.s2.cs_n && !st.s2.clear_n;
		empty_now = (st.count == '0);
		read_try = upd && fifo_mode && !st.s2.cs_n && !st.s2.oe_n;
		read_ok = read_try && !empty_now && st.fsm != CLR_ACTIVE;
		wr_ok = char_write && fifo_mode && st.fsm != CLR_ACTIVE && st.count != FULL_LEVEL;

		// Clear sequencer, stepped on read-clock edges only.
		if (upd) begin
			case (st.fsm)
				CLR_IDLE, CLR_COUNT: begin
					if (arm && st.clr_cnt == CLEAR_EDGES - 3'h1) begin
						next_st.fsm = CLR_ACTIVE;
						next_st.clr_cnt = '0;
					end else if (arm) begin
						next_st.fsm = CLR_COUNT;
						next_st.clr_cnt = st.clr_cnt + 3'h1;
					end else begin
						next_st.fsm = CLR_IDLE;
						next_st.clr_cnt = '0;
					end
				end
				CLR_ACTIVE: begin
					if (st.s2.clear_n || !fifo_mode) begin
						next_st.fsm = CLR_IDLE;
					end
				end
				default: begin
					next_st.fsm = CLR_IDLE;
					next_st.clr_cnt = '0;
				end
			endcase
		end

		// Kept as its own flop so the clear indication leaves the block without any decode.
		next_st.clearing = (next_st.fsm == CLR_ACTIVE);

		// Pointers and occupancy; a clear zeroes them and locks out writes.
		if (next_st.fsm == CLR_ACTIVE) begin
			next_st.wptr = '0;
			next_st.rptr = '0;
			next_st.count = '0;
		end else begin
			if (wr_ok) begin
				next_st.wptr = st.wptr + PTR_W'(1);
			end
			if (read_ok) begin
				next_st.rptr = st.rptr + PTR_W'(1);
				next_st.data = mem[st.rptr];
				next_st.taken = 1'b1;
			end
			if (wr_ok && !read_ok) begin
				next_st.count = st.count + CNT_W'(1);
			end else if (read_ok && !wr_ok) begin
				next_st.count = st.count - CNT_W'(1);
			end
		end

		// Bypass: the outputs load the receiver's character on a read-clock edge with output enabled and the character valid.
		if (upd && !fifo_mode && !st.s2.oe_n && bypass_valid) begin
			next_st.data = bypass_data;
			next_st.taken = 1'b1;
		end

		// Flag levels change only after a read-clock edge; chip reset floats the empty flag at once.
		if (upd) begin
			next_st.half = fifo_mode && next_st.fsm != CLR_ACTIVE
				&& next_st.count >= HALF_LEVEL;
			if (fifo_mode) begin
				next_st.empty = flag_level(next_st.fsm == CLR_ACTIVE
					|| next_st.count == '0, st.s2.pol);
			end else begin
				next_st.empty = flag_level(!bypass_valid
					|| (!st.s2.coding_bypass && bypass_sync), st.s2.pol);
			end
			next_st.empty_oe = !st.s2.cs_n && st.s2.chip_reset_n;
		end
		if (!st.s2.chip_reset_n) begin
			next_st.empty_oe = 1'b0;
		end
		// The half flag floats during chip reset alone and ignores chip select.
		next_st.half_oe = st.s2.chip_reset_n;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st <= '0;
			st.s1 <= PINS_RESET;
			st.s2 <= PINS_RESET;
			st.fsm <= CLR_IDLE;
			st.half <= FLAG_RESET;
			st.half_oe <= OE_RESET;
			st.empty <= FLAG_RESET;
			st.empty_oe <= OE_RESET;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Storage needs no reset; occupancy decides what is valid.
	always_ff @(posedge mclk) begin
		if (ce && wr_ok && next_st.fsm != CLR_ACTIVE) begin
			mem[st.wptr] <= char_data;
		end
	end

	assign rx_half_flag = st.half;
	assign rx_half_flag_oe = st.half_oe;
	assign rx_empty_flag = st.empty;
	assign rx_empty_flag_oe = st.empty_oe;
	assign rx_parallel_out = st.data;
	assign rx_read_taken = st.taken;
	assign clear_active = st.clearing;

	//////////////////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence s_edge_fifo;
		ce && upd && fifo_mode;
	endsequence

	sequence s_clearing;
		ce && upd && st.fsm == CLR_ACTIVE && !st.s2.clear_n && fifo_mode;
	endsequence

	sequence s_arm_run;
		(ce && upd && arm && st.fsm == CLR_COUNT && st.clr_cnt == 3'h6);
	endsequence

	a_half_level: assert property (
		s_edge_fifo and (ce && st.fsm == CLR_IDLE && !arm
		&& st.count >= HALF_LEVEL + CNT_W'(1)) |=> rx_half_flag)
		else $error("half flag missing with FIFO at least half full");

	a_half_low: assert property (
		s_edge_fifo and (ce && st.fsm != CLR_ACTIVE && !arm
		&& st.count + CNT_W'(1) < HALF_LEVEL) |=> !rx_half_flag)
		else $error("half flag set below half full");

	a_half_clear: assert property (s_clearing |=> !rx_half_flag)
		else $error("half flag set during FIFO clear");

	a_half_bypass: assert property (ce && upd && !fifo_mode |=> !rx_half_flag)
		else $error("half flag set in bypass");

	a_half_float: assert property (
		ce |=> rx_half_flag_oe == $past(st.s2.chip_reset_n))
		else $error("half flag enable does not follow chip reset");

	a_empty_drive: assert property (
		ce && upd && st.s2.chip_reset_n
		|=> rx_empty_flag_oe == !$past(st.s2.cs_n))
		else $error("empty flag enable does not follow chip select");

	a_empty_clear: assert property (
		s_arm_run |=> clear_active
		&& rx_empty_flag == $past(st.s2.pol) && st.count == '0)
		else $error("seventh clear edge did not start clear with empty set");

	a_read_empty: assert property (
		s_edge_fifo and (read_try && empty_now && !char_write)
		|=> $stable(st.count) && $stable(st.rptr) && $stable(rx_parallel_out))
		else $error("read while empty changed FIFO state or data");

	a_bypass_sync: assert property (
		ce && upd && !fifo_mode && bypass_valid && bypass_sync
		&& !st.s2.coding_bypass |=> rx_empty_flag == $past(st.s2.pol))
		else $error("sync character not marked by empty flag");

	a_bypass_ready: assert property (
		ce && upd && !fifo_mode && bypass_valid
		&& (!bypass_sync || st.s2.coding_bypass)
		|=> rx_empty_flag == !$past(st.s2.pol))
		else $error("empty flag asserted with bypass character ready");

	a_after_clear: assert property (
		ce && clear_active && !char_write
		##1 (!clear_active && !char_write)[*2] |-> st.count == '0)
		else $error("FIFO not empty after clear without a write");

	a_flag_edge: assert property (
		!(ce && upd) |=> $stable(rx_half_flag) && $stable(rx_empty_flag))
		else $error("status flag changed without a read clock edge");

	a_empty_hold: assert property (
		s_edge_fifo and (st.count == '0 && !char_write)
		|=> rx_empty_flag == $past(st.s2.pol))
		else $error("empty flag not asserted with nothing written");

	a_empty_float: assert property (
		ce && !st.s2.chip_reset_n |=> !rx_empty_flag_oe)
		else $error("empty flag driven during chip reset");

	a_read_advance: assert property (
		s_edge_fifo and (read_try && !empty_now && st.fsm != CLR_ACTIVE)
		|=> rx_read_taken && st.rptr == $past(st.rptr) + PTR_W'(1))
		else $error("accepted read did not advance the read pointer");

endmodule : rx_fifo_flags

`default_nettype wire

/* File: verification/rx_host_model.sv */
// Host side model that makes one read-clock period per request.
`timescale 1ns/10ps
`default_nettype none

module rx_host_model (
	// Clock and request.
	input wire logic mclk,
	input wire logic step,
	// Read clock pin and activity.
	output logic rx_read_clock,
	output logic busy
);
	logic [3:0] cnt = 4'h0;

	// Each phase lasts four mclk, twice the minimum the synchroniser needs.
	// The clock stands low between requests, as a host that only clocks on demand would.
	always_ff @(posedge mclk) begin
		if (step && cnt == 4'h0)
			cnt <= 4'h8;
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
	end
	assign rx_read_clock = cnt > 4'h4;
	assign busy = cnt != 4'h0;
endmodule : rx_host_model

`default_nettype wire

/* File: verification/tb_rx_fifo_flags.sv */
// Self-checking testbench of the receive FIFO status flag block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_rx_fifo_flags;
	import rx_flags_pkg::*;
	localparam int DEPTH = 16;
	logic mclk = 1'h0, rst = 1'h1, step = 1'h0, cs_n = 1'h0, byp_n = 1'h1, clr_n = 1'h1;
	logic oe_n = 1'h1, pol = 1'h1, cbyp = 1'h0, crst_n = 1'h1, wr = 1'h0, bv = 1'h0;
	logic bs = 1'h0, seen = 1'h0, seen_clr = 1'h0;
	logic [9:0] wdat = 10'h000, bdat = 10'h000, pdat;
	logic rclk, busy, half, half_oe, emp, emp_oe, taken, clr_act;
	int n_mismatch = 0, check_count = 0;

	rx_host_model rx_host_model_i (.mclk(mclk), .step(step), .rx_read_clock(rclk), .busy(busy));
	rx_fifo_flags #(.DEPTH(DEPTH), .WIDTH(10)) rx_fifo_flags_i (.mclk(mclk), .rst(rst),
		.ce(1'h1), .rx_read_clock(rclk), .chip_select_n(cs_n), .fifo_bypass_n(byp_n),
		.rx_fifo_clear_n(clr_n), .rx_output_enable_n(oe_n), .flag_polarity_select(pol),
		.coding_bypass(cbyp), .chip_reset_n(crst_n), .char_write(wr), .char_data(wdat),
		.bypass_valid(bv), .bypass_sync(bs), .bypass_data(bdat), .rx_half_flag(half),
		.rx_half_flag_oe(half_oe), .rx_empty_flag(emp), .rx_empty_flag_oe(emp_oe),
		.rx_parallel_out(pdat), .rx_read_taken(taken), .clear_active(clr_act));

	initial begin
		forever #4 mclk = ~mclk;
	end
	// The taken pulse lasts one cycle, so it is caught here and checked later.
	always @(posedge mclk) begin
		if (seen_clr)
			seen <= 1'h0;
		else if (taken)
			seen <= 1'h1;
	end

	////////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("mismatches=%0d checks=%0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize

	// Busy is first looked at one edge after the model has taken the request, so that
	// each call waits out a whole read-clock period and the flag update behind it.
	task automatic edges(input int n);
		int k;
		repeat (n) begin
			@(posedge mclk);
			step <= 1'h1;
			seen_clr <= 1'h1;
			@(posedge mclk);
			step <= 1'h0;
			seen_clr <= 1'h0;
			@(posedge mclk);
			k = 0;
			while (busy && k < 20) begin
				@(posedge mclk);
				k++;
			end
			if (k == 20) begin
				n_mismatch++;
				summarize();
			end
			repeat (2) @(posedge mclk);
		end
	endtask : edges

	task automatic put(input int n);
		repeat (n) begin
			@(posedge mclk);
			wr <= 1'h1;
			wdat <= wdat + 10'h001;
		end
		@(posedge mclk);
		wr <= 1'h0;
	endtask : put

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge mclk);
		rst <= 1'h0;
		repeat (6) @(posedge mclk);
		`CHK(half_oe, 1'h1)
		edges(1);
		`CHK(emp, 1'h1)
		`CHK(emp_oe, 1'h1)
		pol <= 1'h0;
		edges(1);
		`CHK(emp, 1'h0)
		pol <= 1'h1;
		put(DEPTH / 2 - 1);
		edges(1);
		`CHK(half, 1'h0)
		`CHK(emp, 1'h0)
		put(1);
		repeat (8) @(posedge mclk);
		`CHK(half, 1'h0)
		edges(1);
		`CHK(half, 1'h1)
		oe_n <= 1'h0;
		edges(1);
		`CHK(pdat, 10'h001)
		`CHK(seen, 1'h1)
		`CHK(half, 1'h0)
		edges(DEPTH / 2 - 1);
		`CHK(emp, 1'h1)
		edges(1);
		`CHK(seen, 1'h0)
		`CHK(pdat, 10'h008)
		put(DEPTH / 2 + 2);
		oe_n <= 1'h1;
		edges(1);
		`CHK(half, 1'h1)
		clr_n <= 1'h0;
		edges(6);
		`CHK(half, 1'h1)
		`CHK(clr_act, 1'h0)
		edges(1);
		`CHK(clr_act, 1'h1)
		`CHK(half, 1'h0)
		`CHK(emp, 1'h1)
		put(2);
		edges(1);
		`CHK(emp, 1'h1)
		clr_n <= 1'h1;
		edges(1);
		`CHK(clr_act, 1'h0)
		`CHK(emp, 1'h1)
		put(1);
		edges(1);
		`CHK(emp, 1'h0)
		cs_n <= 1'h1;
		edges(1);
		`CHK(emp_oe, 1'h0)
		cs_n <= 1'h0;
		byp_n <= 1'h0;
		bv <= 1'h1;
		bdat <= 10'h2a5;
		edges(1);
		`CHK(half, 1'h0)
		`CHK(emp, 1'h0)
		bs <= 1'h1;
		edges(1);
		`CHK(emp, 1'h1)
		cbyp <= 1'h1;
		edges(1);
		`CHK(emp, 1'h0)
		bs <= 1'h0;
		cbyp <= 1'h0;
		oe_n <= 1'h0;
		edges(1);
		`CHK(pdat, 10'h2a5)
		`CHK(seen, 1'h1)
		bv <= 1'h0;
		edges(1);
		`CHK(emp, 1'h1)
		`CHK(seen, 1'h0)
		crst_n <= 1'h0;
		repeat (6) @(posedge mclk);
		`CHK(half_oe, 1'h0)
		`CHK(emp_oe, 1'h0)
		summarize();
	end
endmodule : tb_rx_fifo_flags

`default_nettype wire
